// >>> common/eeprom_pkg.sv
// Contract
// RL1: Software sets the map enable before loading latches or reading the EEPROM.
// RL2: With map enable set, a pointer store writes the byte into the addressed latch.
// RL3: Software may repeat pointer, data and store steps up to one 128-byte page.
// RL4: The page of the latest latch load becomes the row address for programming.
// RL5: Loads spanning pages keep only the last page; bytes of other pages are discarded.
// RL6: Programming starts only after 5h then Ah in the control command nibble.
// RL7: Hardware holds the program busy flag high while the row is being programmed.
// RL8: While busy, the array cannot be read; read data are not reliable.
// RL9: Hardware clears the busy flag when the row write completes.
// RL10: The two launch writes must be consecutive; anything between aborts the launch. A register read between them does not abort it here.
// RL11: With map enable set, a pointer load returns the stored EEPROM byte.
// RL12: Software saves and disables interrupts around latch load or read sequences.
// RL13: Software loads one or several bytes, all from the same page, before launch.
// RL14: Address bits 10:7 pick the page, bits 6:0 the byte within the latch.
// RL15: Each latch byte has a marker; only marked bytes program; markers clear after.
// RL16: Clearing map enable sends external data moves back to the on-chip XRAM.
// RL17: Software writes never change the busy flag; only hardware sets or clears it.
// RL18: Any other control write or instruction resets the launch tracker.
package eeprom_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 11;
    localparam int PAGE_W = 4;
    localparam int COL_W = 7;
    localparam int PAGE_BYTES = 128;
    localparam int ARRAY_BYTES = 2048;
    localparam int XADDR_W = 16;
    localparam int REG_ADDR_W = 4;
    localparam int EV_W = 2;

    localparam logic [REG_ADDR_W-1:0] OFFSET_CONTROL = 4'h0;
    localparam logic [REG_ADDR_W-1:0] OFFSET_STATUS = 4'h1;
    localparam logic [REG_ADDR_W-1:0] OFFSET_MASK = 4'h2;

    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 4;
    localparam int MAP_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [3:0] LAUNCH_FIRST = 4'h5;
    localparam logic [3:0] LAUNCH_SECOND = 4'ha;

    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;

    localparam int CLOCK_MHZ = 125;
    localparam int PROGRAM_TIME_US = 10000;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
    localparam int TIMER_W = 24;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_copy = 2'b01,
        st_hold = 2'b10
    } prog_state_e;
endpackage : eeprom_pkg

// >>> src/eeprom_array.sv
module eeprom_array
    import eeprom_pkg::*;
(
    input wire logic clock,
    input wire logic ce,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [ARRAY_BYTES];

    always_ff @(posedge clock) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            if (rd_en) begin
                rd_data <= mem[rd_addr];
            end
        end
    end
endmodule : eeprom_array

// >>> src/column_latch.sv
module column_latch
    import eeprom_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [COL_W-1:0] wr_col,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic clear_all,
    input wire logic [COL_W-1:0] rd_col,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_mark
);
    logic [DATA_W-1:0] mem [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mark;
    logic [PAGE_BYTES-1:0] next_mark;

    ////////////////////////////////////////////////////////////////
    // Marker bits, load wins over clear
    always_comb begin
        next_mark = clear_all ? '0 : mark; // RL15
        if (wr_en) begin
            next_mark[wr_col] = 1'b1; // RL15
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mark <= '0;
            rd_mark <= 1'b0;
        end else if (ce) begin
            mark <= next_mark;
            rd_mark <= mark[rd_col];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Latch data
    always_ff @(posedge clock) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_col] <= wr_data;
            end
            rd_data <= mem[rd_col];
        end
    end
endmodule : column_latch

// >>> src/eeprom_page_program_ctrl.sv
module eeprom_page_program_ctrl
    import eeprom_pkg::*;
#(
    parameter int program_cycles = PROGRAM_CYCLES
)(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [eeprom_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [eeprom_pkg::DATA_W-1:0] reg_rdata,
    input wire logic instr_step,
    input wire logic [eeprom_pkg::XADDR_W-1:0] xdata_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] xdata_wdata,
    input wire logic xdata_write,
    input wire logic xdata_read,
    output logic [eeprom_pkg::DATA_W-1:0] xdata_rdata,
    output logic xdata_hit,
    output logic [eeprom_pkg::XADDR_W-1:0] xram_addr,
    output logic [eeprom_pkg::DATA_W-1:0] xram_wdata,
    output logic xram_write,
    output logic xram_read,
    output logic program_busy_flag,
    output logic irq
);
    import eeprom_pkg::*;

    localparam logic [TIMER_W-1:0] HOLD_LAST = TIMER_W'(program_cycles - 1);
    localparam logic [COL_W:0] COL_END = (COL_W+1)'(PAGE_BYTES);

    function automatic logic [PAGE_W-1:0] page_of(input logic [XADDR_W-1:0] a);
        page_of = a[ADDR_W-1:COL_W]; // RL14
    endfunction : page_of

    function automatic logic [COL_W-1:0] col_of(input logic [XADDR_W-1:0] a);
        col_of = a[COL_W-1:0]; // RL14
    endfunction : col_of

    ////////////////////////////////////////////////////////////////
    // Declarations
    logic eeprom_map_enable;
    logic next_map;
    logic [3:0] program_launch_code;
    logic [3:0] next_code;
    logic armed;
    logic next_armed;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] next_status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] next_mask;
    logic [EV_W-1:0] events;
    logic launch;

    prog_state_e state;
    prog_state_e next_state;
    logic [PAGE_W-1:0] row;
    logic [PAGE_W-1:0] next_row;
    logic loaded;
    logic next_loaded;
    logic [COL_W:0] col;
    logic [COL_W:0] next_col;
    logic [COL_W-1:0] prev_col;
    logic [COL_W-1:0] next_prev_col;
    logic copy_valid;
    logic next_copy_valid;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic next_busy;
    logic clear_marks;

    logic ctrl_write;
    logic ee_window;
    logic latch_load;
    logic array_read;
    logic page_switch;
    logic [DATA_W-1:0] latch_q;
    logic latch_mark;
    logic [DATA_W-1:0] next_reg_rdata;
    logic next_irq;

    ////////////////////////////////////////////////////////////////
    // Access steering
    always_comb begin
        ctrl_write = reg_write && (reg_addr == OFFSET_CONTROL);
        ee_window = eeprom_map_enable && (xdata_addr[XADDR_W-1:ADDR_W] == '0); // RL16
        latch_load = xdata_write && ee_window && !program_busy_flag; // RL2
        array_read = xdata_read && ee_window && !program_busy_flag; // RL8 RL11
        page_switch = latch_load && loaded && (page_of(xdata_addr) != row); // RL5
    end

    ////////////////////////////////////////////////////////////////
    // Control register and launch tracker
    always_comb begin
        next_map = eeprom_map_enable;
        next_code = program_launch_code;
        next_armed = armed;
        launch = 1'b0;
        events = '0;
        if (ctrl_write) begin
            next_map = reg_wdata[MAP_BIT];
            next_code = reg_wdata[CODE_MSB:CODE_LSB];
            if (armed && reg_wdata[CODE_MSB:CODE_LSB] == LAUNCH_SECOND) begin
                next_armed = 1'b0;
                launch = !program_busy_flag; // RL6
            end else begin
                next_armed = (reg_wdata[CODE_MSB:CODE_LSB] == LAUNCH_FIRST); // RL18
                events[EV_ABORT] = armed; // RL10
            end
        end else if (armed && (instr_step || reg_write || xdata_write || xdata_read)) begin
            next_armed = 1'b0; // RL10 RL18
            events[EV_ABORT] = 1'b1;
        end
        if (state == st_hold && timer == HOLD_LAST) begin
            events[EV_DONE] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            eeprom_map_enable <= 1'b0;
            program_launch_code <= 4'h0;
            armed <= 1'b0;
        end else if (ce) begin
            eeprom_map_enable <= next_map;
            program_launch_code <= next_code;
            armed <= next_armed;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    always_comb begin
        next_status = status;
        next_mask = mask;
        if (reg_write && reg_addr == OFFSET_STATUS) begin
            next_status = status & ~reg_wdata[EV_W-1:0];
        end
        if (reg_write && reg_addr == OFFSET_MASK) begin
            next_mask = reg_wdata[EV_W-1:0];
        end
        next_status = next_status | events;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register read port
    always_comb begin
        next_reg_rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                OFFSET_CONTROL: begin
                    next_reg_rdata[CODE_MSB:CODE_LSB] = program_launch_code;
                    next_reg_rdata[MAP_BIT] = eeprom_map_enable;
                    next_reg_rdata[BUSY_BIT] = program_busy_flag; // RL7
                end
                OFFSET_STATUS: next_reg_rdata[EV_W-1:0] = status;
                OFFSET_MASK: next_reg_rdata[EV_W-1:0] = mask;
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // XRAM pass-through when unmapped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            xram_addr <= '0;
            xram_wdata <= '0;
            xram_write <= 1'b0;
            xram_read <= 1'b0;
            xdata_hit <= 1'b0;
        end else if (ce) begin
            xram_addr <= xdata_addr;
            xram_wdata <= xdata_wdata;
            xram_write <= xdata_write && !ee_window; // RL16
            xram_read <= xdata_read && !ee_window; // RL16
            xdata_hit <= xdata_read && ee_window;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Row programming sequencer
    always_comb begin
        next_state = state;
        next_row = row;
        next_loaded = loaded;
        next_col = col;
        next_prev_col = prev_col;
        next_copy_valid = 1'b0;
        next_timer = timer;
        next_busy = program_busy_flag;
        clear_marks = page_switch; // RL5
        if (latch_load) begin
            next_row = page_of(xdata_addr); // RL4
            next_loaded = 1'b1;
        end
        case (state)
            st_idle: begin
                if (launch) begin
                    next_state = st_copy;
                    next_busy = 1'b1; // RL7
                    next_col = '0;
                end
            end
            st_copy: begin
                if (col != COL_END) begin
                    next_prev_col = col[COL_W-1:0];
                    next_col = col + 1'b1;
                    next_copy_valid = 1'b1;
                end else begin
                    next_state = st_hold;
                    next_timer = '0;
                end
            end
            st_hold: begin
                if (timer == HOLD_LAST) begin
                    next_state = st_idle;
                    next_busy = 1'b0; // RL9
                    next_loaded = 1'b0;
                    clear_marks = 1'b1; // RL15
                end else begin
                    next_timer = timer + 1'b1;
                end
            end
            default: begin
                next_state = st_idle;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= st_idle;
            row <= '0;
            loaded <= 1'b0;
            col <= '0;
            prev_col <= '0;
            copy_valid <= 1'b0;
            timer <= '0;
            program_busy_flag <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            row <= next_row;
            loaded <= next_loaded;
            col <= next_col;
            prev_col <= next_prev_col;
            copy_valid <= next_copy_valid;
            timer <= next_timer;
            program_busy_flag <= next_busy; // RL17
        end
    end

    ////////////////////////////////////////////////////////////////
    // Storage
    column_latch latch (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .wr_en(latch_load), // RL2
        .wr_col(col_of(xdata_addr)),
        .wr_data(xdata_wdata),
        .clear_all(clear_marks),
        .rd_col(col[COL_W-1:0]),
        .rd_data(latch_q),
        .rd_mark(latch_mark)
    );

    eeprom_array array (
        .clock(clock),
        .ce(ce),
        .rd_en(array_read), // RL11
        .rd_addr(xdata_addr[ADDR_W-1:0]),
        .rd_data(xdata_rdata),
        .wr_en(copy_valid && latch_mark), // RL15
        .wr_addr({row, prev_col}), // RL4
        .wr_data(latch_q)
    );
endmodule : eeprom_page_program_ctrl

// >>> verification/eeprom_ctrl_sva.sv
module eeprom_ctrl_sva
    import eeprom_pkg::*;
#(
    parameter int program_cycles = 8
)(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [eeprom_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [eeprom_pkg::DATA_W-1:0] reg_rdata,
    input wire logic instr_step,
    input wire logic [eeprom_pkg::XADDR_W-1:0] xdata_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] xdata_wdata,
    input wire logic xdata_write,
    input wire logic xdata_read,
    input wire logic [eeprom_pkg::DATA_W-1:0] xdata_rdata,
    input wire logic xdata_hit,
    input wire logic [eeprom_pkg::XADDR_W-1:0] xram_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] xram_wdata,
    input wire logic xram_write,
    input wire logic xram_read,
    input wire logic program_busy_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY_MAX = PAGE_BYTES + program_cycles + 8;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    sequence ctrl_first;
        reg_write && reg_addr == OFFSET_CONTROL && reg_wdata[7:4] == LAUNCH_FIRST && !program_busy_flag;
    endsequence
    sequence ctrl_second;
        reg_write && reg_addr == OFFSET_CONTROL && reg_wdata[7:4] == LAUNCH_SECOND;
    endsequence
    sequence other_instr;
        instr_step && !reg_write;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_launch_sets_busy: assert property (ctrl_first ##1 ctrl_second |=> program_busy_flag)
        else $error("busy not raised by launch pair");
    a_gap_aborts: assert property (ctrl_first ##1 other_instr ##1 ctrl_second |=> !program_busy_flag)
        else $error("launch not aborted by gap");
    a_busy_holds: assert property ($rose(program_busy_flag) |-> program_busy_flag [*8])
        else $error("busy dropped too early");
    a_busy_ends: assert property ($rose(program_busy_flag) |-> ##[1:BUSY_MAX] !program_busy_flag)
        else $error("busy never cleared");
    a_sw_busy: assert property (reg_write && !program_busy_flag && reg_wdata[7:4] != LAUNCH_SECOND
        |=> !program_busy_flag)
        else $error("software changed busy");
    a_busy_readback: assert property (reg_read && reg_addr == OFFSET_CONTROL
        |=> reg_rdata[BUSY_BIT] == $past(program_busy_flag))
        else $error("busy readback wrong");
    a_read_route: assert property (xdata_read |=> xdata_hit != xram_read)
        else $error("read routed twice or nowhere");
    a_busy_stale: assert property (program_busy_flag && xdata_read && xdata_addr[15:11] == 5'h00
        |=> xram_read || (xdata_hit && $stable(xdata_rdata)))
        else $error("array read while busy");
    a_xram_fwd: assert property (xdata_write && xdata_addr[15:11] != 5'h00
        |=> xram_write && xram_addr == $past(xdata_addr) && xram_wdata == $past(xdata_wdata))
        else $error("store outside window not forwarded");
endmodule : eeprom_ctrl_sva

// >>> verification/core_model.sv
module core_model
    import eeprom_pkg::*;
(
    input wire logic clock,
    output logic instr_step,
    output logic [eeprom_pkg::XADDR_W-1:0] xdata_addr,
    output logic [eeprom_pkg::DATA_W-1:0] xdata_wdata,
    output logic xdata_write,
    output logic xdata_read,
    input wire logic [eeprom_pkg::DATA_W-1:0] xdata_rdata,
    input wire logic xdata_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Interrupts held off: moves never split
    initial begin
        instr_step = 1'b0;
        xdata_addr = '0;
        xdata_wdata = '0;
        xdata_write = 1'b0;
        xdata_read = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Pointer store of accumulator byte
    task store(input logic [XADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        xdata_addr <= a;
        xdata_wdata <= d;
        xdata_write <= 1'b1;
        @(posedge clock);
        xdata_write <= 1'b0;
        xdata_addr <= ~a;
        xdata_wdata <= ~d;
        #1;
    endtask : store
    // Pointer load into accumulator
    task load(input logic [XADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic hit);
        xdata_addr <= a;
        xdata_read <= 1'b1;
        @(posedge clock);
        xdata_read <= 1'b0;
        xdata_addr <= ~a;
        #1;
        d = xdata_rdata;
        hit = xdata_hit;
    endtask : load
    // Any other instruction
    task step();
        instr_step <= 1'b1;
        @(posedge clock);
        instr_step <= 1'b0;
        #1;
    endtask : step
endmodule : core_model

// >>> verification/testbench.sv
`define check(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import eeprom_pkg::*;
    logic clock, resetn, reg_write, reg_read, instr_step, xdata_write, xdata_read;
    logic xdata_hit, xram_write, xram_read, program_busy_flag, irq, hit, ce;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, xdata_wdata, xdata_rdata, xram_wdata, d;
    logic [XADDR_W-1:0] xdata_addr, xram_addr;
    int fail_count = 0;
    int cmp_count = 0;
    eeprom_page_program_ctrl #(.program_cycles(8)) eeprom_page_program_ctrl_i (
        .clock(clock), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_step(instr_step),
        .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata), .xdata_write(xdata_write),
        .xdata_read(xdata_read), .xdata_rdata(xdata_rdata), .xdata_hit(xdata_hit),
        .xram_addr(xram_addr), .xram_wdata(xram_wdata), .xram_write(xram_write),
        .xram_read(xram_read), .program_busy_flag(program_busy_flag), .irq(irq));
    core_model core_model_i (.clock(clock), .instr_step(instr_step), .xdata_addr(xdata_addr),
        .xdata_wdata(xdata_wdata), .xdata_write(xdata_write), .xdata_read(xdata_read),
        .xdata_rdata(xdata_rdata), .xdata_hit(xdata_hit));
    ////////////////////////////////////////////////////////////////
    task results();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task wr(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task wait_idle();
        int n;
        for (n = 0; n < 400 && program_busy_flag !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        if (n >= 400) begin
            fail_count++;
            results();
        end
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        results();
    end
    initial begin
        resetn = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        ce = 1'b1;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        wr(OFFSET_CONTROL, 8'h01);
        rd(OFFSET_CONTROL, d);
        `check(d, 8'h00)
        wr(4'hf, 8'hff);
        rd(4'hf, d);
        `check(d, 8'h00)
        wr(OFFSET_MASK, 8'h03);
        wr(OFFSET_CONTROL, 8'h02);
        core_model_i.store(16'h0085, 8'h11);
        core_model_i.store(16'h0086, 8'h22);
        wr(OFFSET_CONTROL, 8'h52);
        wr(OFFSET_CONTROL, 8'ha2);
        rd(OFFSET_CONTROL, d);
        `check(d[BUSY_BIT], 1'b1)
        wr(OFFSET_CONTROL, 8'h02);
        rd(OFFSET_CONTROL, d);
        `check(d[BUSY_BIT], 1'b1)
        core_model_i.load(16'h0085, d, hit);
        `check(hit, 1'b1)
        wait_idle();
        `check(irq, 1'b1)
        rd(OFFSET_STATUS, d);
        `check(d, 8'h01)
        wr(OFFSET_STATUS, 8'h01);
        rd(OFFSET_STATUS, d);
        `check(d, 8'h00)
        `check(irq, 1'b0)
        core_model_i.store(16'h0085, 8'h3c);
        core_model_i.store(16'h0103, 8'h77);
        wr(OFFSET_CONTROL, 8'h52);
        wr(OFFSET_CONTROL, 8'ha2);
        wait_idle();
        core_model_i.load(16'h0085, d, hit);
        `check(d, 8'h11)
        core_model_i.load(16'h0086, d, hit);
        `check(d, 8'h22)
        core_model_i.load(16'h0103, d, hit);
        `check(d, 8'h77)
        `check(hit, 1'b1)
        wr(OFFSET_STATUS, 8'h03);
        wr(OFFSET_CONTROL, 8'h52);
        core_model_i.step();
        wr(OFFSET_CONTROL, 8'ha2);
        rd(OFFSET_CONTROL, d);
        `check(d[BUSY_BIT], 1'b0)
        rd(OFFSET_STATUS, d);
        `check(d[EV_ABORT], 1'b1)
        wr(OFFSET_CONTROL, 8'ha2);
        rd(OFFSET_CONTROL, d);
        `check(d[BUSY_BIT], 1'b0)
        wr(OFFSET_CONTROL, 8'h00);
        core_model_i.load(16'h0085, d, hit);
        `check(hit, 1'b0)
        `check(xram_read, 1'b1)
        core_model_i.store(16'h0900, 8'h5a);
        `check(xram_write, 1'b1)
        `check(xram_addr, 16'h0900)
        ce <= 1'b0;
        wr(OFFSET_MASK, 8'h00);
        ce <= 1'b1;
        rd(OFFSET_MASK, d);
        `check(d, 8'h03)
        results();
    end
endmodule : testbench
bind eeprom_page_program_ctrl eeprom_ctrl_sva #(.program_cycles(program_cycles)) sva_i (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_step(instr_step),
    .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata), .xdata_write(xdata_write),
    .xdata_read(xdata_read), .xdata_rdata(xdata_rdata), .xdata_hit(xdata_hit),
    .xram_addr(xram_addr), .xram_wdata(xram_wdata), .xram_write(xram_write),
    .xram_read(xram_read), .program_busy_flag(program_busy_flag));
